// >>> hw/cdd_clock_divider.sv
// input clock divider with alignment pulse and duty-cycle retimer
`timescale 1ns/1ps
module cdd_clock_divider import cdd_pkg::*; #(
  parameter int PER_W = 8, // width of period measurement
  parameter int DIV_MAX = CDD_DIV_MAX // largest divide ratio
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // sample clock and alignment pulse from outside
  input wire logic sample_clk_in,
  input wire logic sync_in,
  // register port
  input wire logic reg_wr,
  input wire logic [12:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_r,
  // clock configuration
  input wire logic [2:0] div_sel, // ratio minus one
  input wire logic retimer_en, // duty_cycle_retimer enable setting
  input wire logic strap_mode, // pin-strapped configuration
  input wire logic serial_io_retimer_strap,
  // converter core side
  output logic conv_clk_r,
  output logic conv_rise_r, // one-cycle pulse at each sampling edge
  output logic retime_active_r,
  output logic locked_r,
  output logic sync_armed_r
);
  initial begin
    if (DIV_MAX < CDD_DIV_MIN || DIV_MAX > CDD_DIV_MAX) begin
      $error("cdd_clock_divider: DIV_MAX out of range");
    end
  end

  logic in_q_r; // previous sample clock level
  logic in_rise; // sample clock rising
  logic in_fall; // sample clock falling
  logic sync_s1_r; // synchroniser first stage
  logic sync_s2_r; // synchroniser second stage
  logic sync_s3_r; // edge detect stage
  logic sync_rise; // synchronized pulse edge
  logic sync_acc; // pulse accepted for realignment
  logic ctrl_wr; // write to clock_alignment_control
  logic [7:0] ctrl_r; // clock_alignment_control
  logic [2:0] div_cnt_r; // divider phase
  logic [2:0] div_last; // last phase for chosen ratio
  logic conv_rise; // divided rising edge this cycle
  logic retimer_on; // retimer requested
  logic [PER_W-1:0] hi_cnt_r; // cycles since divided rise
  logic [PER_W-1:0] half; // retimed high time
  logic loop_locked; // lock from the retimer loop
  logic fall_now; // divided clock falls this cycle
  logic [7:0] low_cnt_r; // cycles since the loop lost lock

  assign in_rise = sample_clk_in && !in_q_r;
  assign in_fall = !sample_clk_in && in_q_r;
  assign sync_rise = sync_s2_r && !sync_s3_r;
  assign ctrl_wr = reg_wr && (reg_addr == CDD_ADDR_CLK_ALIGN);
  // when enabled, every pulse, or only while armed in first-only mode
  assign sync_acc = sync_rise && ctrl_r[CDD_SYNC_EN_BIT] &&
                    (!ctrl_r[CDD_SYNC_FIRST_BIT] || sync_armed_r);
  // clamp the ratio to what this build supports
  assign div_last = (32'(div_sel) >= DIV_MAX) ? 3'(DIV_MAX - 1) : div_sel;
  // accepted pulse suppresses the rise in its own cycle
  assign conv_rise = in_rise && (div_cnt_r == CDD_DIV_CNT_RESET) && !sync_acc;
  // strap pin replaces the enable in pin mode; ratio above one forces it
  assign retimer_on = (div_last != 3'h0) ||
                      (strap_mode ? serial_io_retimer_strap : retimer_en);
  // retimed fall at half period, else follow the raw input fall
  assign fall_now = retime_active_r ? (hi_cnt_r >= half) : in_fall;

  // sample clock edge history and pulse synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_q_r <= 1'b0;
      sync_s1_r <= 1'b0;
      sync_s2_r <= 1'b0;
      sync_s3_r <= 1'b0;
    end else begin
      in_q_r <= sample_clk_in;
      sync_s1_r <= sync_in;
      sync_s2_r <= sync_s1_r;
      sync_s3_r <= sync_s2_r;
    end
  end

  // control register and readback
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CDD_CTRL_RESET;
      reg_rdata_r <= 8'h00;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= reg_wdata;
      end
      // unmapped addresses read zero
      reg_rdata_r <= (reg_addr == CDD_ADDR_CLK_ALIGN) ? ctrl_r : 8'h00;
    end
  end

  // arming for first-only mode: a write re-arms even over a taken pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_armed_r <= 1'b0;
    end else if (ctrl_wr) begin
      sync_armed_r <= 1'b1;
    end else if (sync_acc) begin
      sync_armed_r <= 1'b0;
    end
  end

  // divider phase counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= CDD_DIV_CNT_RESET;
    end else if (sync_acc) begin
      div_cnt_r <= CDD_DIV_CNT_RESET;
    end else if (in_rise) begin
      div_cnt_r <= (div_cnt_r >= div_last) ? CDD_DIV_CNT_RESET : div_cnt_r + 3'h1;
    end
  end

  cdd_retimer #(.PER_W(PER_W)) u_retimer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rise(conv_rise),
    .locked_r(loop_locked),
    .half_r(half)
  );

  // retimer engagement: only when requested and locked
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      retime_active_r <= 1'b0;
      locked_r <= 1'b0;
    end else begin
      retime_active_r <= retimer_on && loop_locked;
      locked_r <= loop_locked;
    end
  end

  // divided clock: rise on the sampling edge, fall raw or retimed
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_clk_r <= 1'b0;
      conv_rise_r <= 1'b0;
      hi_cnt_r <= '0;
    end else begin
      conv_rise_r <= conv_rise;
      if (conv_rise) begin
        conv_clk_r <= 1'b1;
        hi_cnt_r <= PER_W'(1);
      end else if (conv_clk_r && fall_now) begin
        conv_clk_r <= 1'b0;
      end else if (conv_clk_r && hi_cnt_r != {PER_W{1'b1}}) begin
        hi_cnt_r <= hi_cnt_r + PER_W'(1);
      end
    end
  end

  // time out of lock, so the relock check does not lean on the loop's own timer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_r <= 8'h00;
    end else if (loop_locked) begin
      low_cnt_r <= 8'h00; // locked, nothing to count
    end else if (low_cnt_r != 8'hff) begin
      low_cnt_r <= low_cnt_r + 8'h01; // saturates on long losses
    end
  end

  // checks
  sync_resets_div_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sync_acc |=> div_cnt_r == CDD_DIV_CNT_RESET)
    else $error("accepted pulse did not reset divider");
  first_only_disarm_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sync_acc && !ctrl_wr && ctrl_r[CDD_SYNC_FIRST_BIT]) |=> !sync_armed_r)
    else $error("first-only mode stayed armed");
  ignored_when_disarmed_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sync_rise && ctrl_r[CDD_SYNC_FIRST_BIT] && !sync_armed_r && !ctrl_wr && !in_rise)
    |=> div_cnt_r == $past(div_cnt_r))
    else $error("pulse accepted while disarmed");
  forced_retimer_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (div_last != 3'h0 && loop_locked) |=> retime_active_r)
    else $error("retimer not forced for ratio above one");
  strap_select_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (strap_mode && !serial_io_retimer_strap && div_last == 3'h0) |=> !retime_active_r)
    else $error("strap low did not disable retimer");
  bypass_follows_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!retime_active_r && conv_clk_r && in_fall && !conv_rise) |=> !conv_clk_r)
    else $error("bypass did not follow input fall");
  rise_at_phase_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(conv_clk_r) |-> $past(in_rise) && $past(div_cnt_r) == CDD_DIV_CNT_RESET)
    else $error("divided rise off phase zero");
  retimed_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (retime_active_r && conv_clk_r && hi_cnt_r < half && !in_rise) |=> conv_clk_r)
    else $error("retimed clock fell early");
  lock_needs_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(loop_locked) |-> low_cnt_r >= 8'(CDD_RELOCK_MIN_CYC))
    else $error("loop relocked before the least wait");

  realign_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    sync_acc && div_cnt_r != CDD_DIV_CNT_RESET);
  retimed_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    retime_active_r && $fell(conv_clk_r));
  first_only_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    sync_rise && ctrl_r[CDD_SYNC_FIRST_BIT] && !sync_armed_r);
  div8_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    div_last == 3'h7 && conv_rise);
  bypass_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    !retime_active_r && locked_r && $fell(conv_clk_r));
endmodule

// >>> hw/cdd_pkg.sv
// shared constants for the clock divider and duty-cycle retimer
package cdd_pkg;
  // register map
  localparam logic [12:0] CDD_ADDR_CLK_ALIGN = 13'h100; // clock_alignment_control
  localparam logic [7:0] CDD_CTRL_RESET = 8'h00; // value after reset
  localparam int CDD_SYNC_EN_BIT = 1; // realign on alignment pulses
  localparam int CDD_SYNC_FIRST_BIT = 2; // only first pulse after a write
  // divider range
  localparam int CDD_DIV_MIN = 1;
  localparam int CDD_DIV_MAX = 8;
  // reference clock and relock timing
  localparam int CDD_CLK_PERIOD_NS = 50; // 20 MHz ref_clk
  localparam int CDD_RELOCK_MIN_NS = 1500; // least relock wait
  localparam int CDD_RELOCK_MAX_NS = 5000; // longest relock wait
  // least time rounds up, longest rounds down
  localparam int CDD_RELOCK_MIN_CYC =
    (CDD_RELOCK_MIN_NS + CDD_CLK_PERIOD_NS - 1) / CDD_CLK_PERIOD_NS;
  localparam int CDD_RELOCK_MAX_CYC = CDD_RELOCK_MAX_NS / CDD_CLK_PERIOD_NS;
  // reset values of counters
  localparam logic [2:0] CDD_DIV_CNT_RESET = 3'h0;
endpackage

// >>> hw/cdd_retimer.sv
// duty-cycle retimer loop: measures the divided period and reports lock
`timescale 1ns/1ps
module cdd_retimer import cdd_pkg::*; #(
  parameter int PER_W = 8 // width of the period counter
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // rising edge of the divided clock
  input wire logic rise,
  // loop state
  output logic locked_r,
  output logic [PER_W-1:0] half_r
);
  localparam logic [PER_W-1:0] PER_MAX = {PER_W{1'b1}}; // slow or stopped input
  localparam logic [PER_W-1:0] RELOCK = PER_W'(CDD_RELOCK_MIN_CYC);

  initial begin
    if (PER_W < 3 || CDD_RELOCK_MIN_CYC >= 2 ** PER_W) begin
      $error("cdd_retimer: PER_W too small");
    end
  end

  logic [PER_W-1:0] per_cnt_r; // cycles since last rise
  logic [PER_W-1:0] per_last_r; // last measured period
  logic [PER_W-1:0] stable_r; // cycles with steady period
  logic [PER_W-1:0] stable_nxt;
  logic [PER_W-1:0] period; // period ending at this rise
  logic match; // period unchanged and in range

  assign period = per_cnt_r + PER_W'(1);
  assign match = (period == per_last_r) && (per_cnt_r != PER_MAX);

  // period counter, saturates when the input is too slow
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt_r <= '0;
      per_last_r <= '0;
      half_r <= PER_W'(1);
    end else if (rise) begin
      per_cnt_r <= '0;
      per_last_r <= period;
      // half of the period, never below one cycle
      half_r <= (period < PER_W'(2)) ? PER_W'(1) : (period >> 1);
    end else if (per_cnt_r != PER_MAX) begin
      per_cnt_r <= per_cnt_r + PER_W'(1);
    end
  end

  // stability timer: any change of period or a slow input restarts it
  always_comb begin
    stable_nxt = stable_r;
    if ((rise && !match) || per_cnt_r == PER_MAX) begin
      stable_nxt = '0;
    end else if (stable_r != RELOCK) begin
      stable_nxt = stable_r + PER_W'(1);
    end
  end

  // lock flag after the least relock time of steady input
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stable_r <= '0;
      locked_r <= 1'b0;
    end else begin
      stable_r <= stable_nxt;
      locked_r <= (stable_nxt == RELOCK);
    end
  end
endmodule

// >>> test/cdd_src_model.sv
// sample clock source and alignment pulse driver facing the divider
`timescale 1ns/1ps
module cdd_src_model (
  // clock
  input wire logic ref_clk,
  // source shape in ref cycles and pulse request
  input wire logic [7:0] per,
  input wire logic [7:0] hi,
  input wire logic sync_req,
  // lines into the divider
  output logic sample_clk_in,
  output logic sync_in
);
  logic [7:0] cnt_r = 8'h00; // phase within the source period
  logic [1:0] pul_r = 2'h0; // pulse cycles left
  // free running source clock with a raw duty of hi/per
  assign sample_clk_in = (cnt_r < hi);
  // pulse stays low between requests
  assign sync_in = (pul_r != 2'h0);
  // update shortly after each edge, never on it
  always @(posedge ref_clk) begin
    cnt_r <= #2 (cnt_r + 8'h01 >= per) ? 8'h00 : cnt_r + 8'h01;
    pul_r <= #2 sync_req ? 2'h2 : (pul_r != 2'h0 ? pul_r - 2'h1 : 2'h0);
  end
endmodule

// >>> test/tb_top.sv
// self-checking bench for the clock divider and retimer
`timescale 1ns/1ps
module tb_top import cdd_pkg::*;;
  logic ref_clk = 1'b0, rst_n = 1'b0, sync_req = 1'b0, reg_wr = 1'b0, pend = 1'b0;
  logic [12:0] reg_addr = 13'h0000;
  logic [7:0] reg_wdata = 8'h00, per = 8'h06, hi = 8'h02, reg_rdata_r;
  logic [2:0] div_sel = 3'h0;
  logic retimer_en = 1'b0, strap_mode = 1'b0, strap = 1'b0, sample_clk_in, sync_in;
  logic conv_clk_r, conv_rise_r, retime_active_r, locked_r, sync_armed_r;
  logic [17:0] q[$]; // expected notes: kind then value
  logic [31:0] seed = 32'h0000f704; // random state
  int error_cnt = 0, checks = 0, cyc = 0, lastr = 0, hcnt = 0;
  // 20 MHz reference clock
  initial forever #25 ref_clk = ~ref_clk;
  cdd_src_model src (.ref_clk(ref_clk), .per(per), .hi(hi), .sync_req(sync_req),
    .sample_clk_in(sample_clk_in), .sync_in(sync_in));
  cdd_clock_divider DUT (.ref_clk(ref_clk), .rst_n(rst_n), .sample_clk_in(sample_clk_in),
    .sync_in(sync_in), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .div_sel(div_sel), .retimer_en(retimer_en),
    .strap_mode(strap_mode), .serial_io_retimer_strap(strap), .conv_clk_r(conv_clk_r),
    .conv_rise_r(conv_rise_r), .retime_active_r(retime_active_r), .locked_r(locked_r),
    .sync_armed_r(sync_armed_r));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // step whole cycles, landing just after the edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #2;
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask
  // read data or status becomes due one cycle after the address
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    reg_addr = a;
    tick(1);
    q.push_back({2'h0, 8'h00, e});
    pend = 1'b1;
    tick(1);
  endtask
  task automatic st(input logic [2:0] e);
    q.push_back({2'h1, 13'h0000, e});
    pend = 1'b1;
    tick(1);
  endtask
  // wait, bounded, for the monitor to use up all notes
  task automatic drain;
    repeat (600) if (q.size() != 0) @(posedge ref_clk);
    if (q.size() != 0) chk(16'hdead, 16'h0000);
    q.delete();
    tick(1);
  endtask
  // three conv periods: n source periods long, raw or half high time
  task automatic shape(input int n, input logic [7:0] p, h, input bit rt);
    int w;
    w = n * p;
    repeat (3) q.push_back({2'h2, 8'(w), rt ? 8'((w < 2) ? 1 : w / 2) : h});
    drain();
  endtask
  // alignment pulse issued just after a conv rise
  task automatic pulse(input logic [17:0] note);
    @(posedge ref_clk iff conv_rise_r === 1'b1);
    #2 sync_req = 1'b1;
    q.push_back(note);
    tick(1);
    sync_req = 1'b0;
    drain();
  endtask
  // monitor: samples settled outputs and takes the oldest note
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (pend) begin
      pend = 1'b0;
      if (q[0][17:16] == 2'h0) chk({8'h00, reg_rdata_r}, q[0][15:0]);
      else chk({13'h0000, retime_active_r, locked_r, sync_armed_r}, q[0][15:0]);
      void'(q.pop_front());
    end
    if (conv_rise_r === 1'b1) begin
      if (q.size() > 0 && q[0][17] === 1'b1) begin
        if (q[0][16]) chk({15'h0000, (cyc - lastr) <= q[0][15:8]}, 16'h0001);
        else chk({8'(cyc - lastr), 8'(hcnt)}, q[0][15:0]);
        void'(q.pop_front());
      end
      lastr = cyc;
      hcnt = 1;
    end else if (conv_clk_r === 1'b1) hcnt = hcnt + 1;
  end
  // watchdog well beyond the expected run
  initial begin
    repeat (9000) @(posedge ref_clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    tick(1);
    rd(CDD_ADDR_CLK_ALIGN, CDD_CTRL_RESET);
    wr(13'h00a0, 8'hff);
    rd(13'h00a0, 8'h00);
    $display("test registers done");
    tick(200);
    shape(1, 8'h06, 8'h02, 0);
    st(3'b010);
    retimer_en = 1'b1;
    tick(5);
    st(3'b110);
    shape(1, 8'h06, 8'h02, 1);
    retimer_en = 1'b0;
    for (int d = 1; d < 8; d++) begin
      seed = xs(seed);
      per = 8'h04 + 8'(seed[7:0] % 8);
      hi = 8'h01 + 8'(seed[15:8] % (per - 8'h01));
      div_sel = 3'(d);
      tick(300);
      shape(d + 1, per, hi, 1);
      st(3'b110);
    end
    $display("test ratios done");
    div_sel = 3'h0;
    strap_mode = 1'b1;
    strap = 1'b1;
    per = 8'h06;
    hi = 8'h01;
    tick(200);
    st(3'b110);
    strap = 1'b0;
    tick(10);
    st(3'b010);
    shape(1, 8'h06, 8'h01, 0);
    strap_mode = 1'b0;
    div_sel = 3'h3;
    tick(200);
    $display("test strap done");
    wr(CDD_ADDR_CLK_ALIGN, 8'h04);
    pulse({2'h2, 8'h18, 8'h0c});
    wr(CDD_ADDR_CLK_ALIGN, 8'h06);
    st(3'b111);
    pulse({2'h3, 8'h0e, 8'h00});
    st(3'b000);
    tick(150);
    pulse({2'h2, 8'h18, 8'h0c});
    wr(CDD_ADDR_CLK_ALIGN, 8'h02);
    pulse({2'h3, 8'h0e, 8'h00});
    pulse({2'h3, 8'h0e, 8'h00});
    rd(CDD_ADDR_CLK_ALIGN, 8'h02);
    $display("test alignment done");
    finish_test();
  end
endmodule
